// ### inc/io_channel_cycle_steal_arbiter_consts.vh
// Constants for the I/O channel cycle-steal arbiter
`ifndef IO_CHANNEL_CYCLE_STEAL_ARBITER_CONSTS_VH
`define IO_CHANNEL_CYCLE_STEAL_ARBITER_CONSTS_VH

// Clock period of ref_clk
`define CLK_PERIOD_NS 25
// Fastest channel clock period
`define PULSE_FAST_NS 100
// Second channel clock period
`define PULSE_512_US 512
// 512 us counted in 100 ns ticks
`define MID_TICKS_DEFAULT 13'h1400
// Nanoseconds in one microsecond
`define NS_PER_US 1000
// Ratios of the slower channel clocks to the 512 us clock
`define RATIO_1024 2
`define RATIO_131 256
`define RATIO_1048 2048

// Counter widths
`define FAST_W 3
`define MID_W 13
`define R1024_W 1
`define R131_W 8
`define R1048_W 11

// Command count at which the ID command is dropped; it is held on the bus for five cycles
`define ID_CMD_CYCLES 4'h4
// Cycle in the command at which the synchronised bus is sampled
`define ID_SAMPLE_AT 4'h3

// Fault byte bits that redefine the last-operation digit
`define FAULT_CTX_A 6
`define FAULT_CTX_B 7

// Reset values
`define FAULT_RESET 8'h00
`define LASTOP_RESET 8'h00
`define LOW_NIBBLE 4'h0

`endif

// ### verification/cs_attachments.sv
// Attachments answering the cycle-steal identification command
`timescale 1ns/1ps
`default_nettype none
module cs_attachments (
    input wire logic ref_clk,
    input wire logic idCommand,
    input wire logic [0:7] reqMask,
    output wire logic [0:7] idBus
);
    logic [0:7] lastDriven = 8'h00;
    always @(posedge ref_clk) begin
        if (idCommand) lastDriven <= reqMask;
    end
    // Drive own bits; released bus shows the inverse of the last answer
    assign #1 idBus = idCommand ? reqMask : ~lastDriven;
endmodule
`default_nettype wire

// ### verification/io_channel_cycle_steal_arbiter_properties.sv
// Port-level properties of the cycle-steal arbiter
`timescale 1ns/1ps
`default_nettype none
module io_channel_cycle_steal_arbiter_properties (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic csRecognized,
    input wire logic intBlocked,
    input wire logic idCommand,
    input wire logic grantValid,
    input wire logic [2:0] grantBit,
    input wire logic [0:7] errorDetect,
    input wire logic lastOpLoad,
    input wire logic [0:7] lastOpWrData,
    input wire logic senseFault,
    input wire logic [0:7] senseData,
    input wire logic [0:7] panelFault,
    input wire logic [0:7] panelLastOp,
    input wire logic diagHalt,
    input wire logic [4:0] chanClock
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_cmdCause; $rose(idCommand) |-> $past(csRecognized && !intBlocked); endproperty
    a_cmdCause: assert property (p_cmdCause) else $error("command without request");
    property p_cmdLen; $rose(idCommand) |-> idCommand [*5] ##1 !idCommand; endproperty
    a_cmdLen: assert property (p_cmdLen) else $error("command length");
    property p_grantAt; grantValid |-> $past(idCommand, 4) && !$past(idCommand, 5); endproperty
    a_grantAt: assert property (p_grantAt) else $error("grant timing");
    property p_grantRec; grantValid && !$past(lastOpLoad) && panelFault[6:7] == 2'b00
        |=> panelLastOp[0:3] == {1'b0, grantBit}; endproperty
    a_grantRec: assert property (p_grantRec) else $error("grant not recorded");
    property p_lowNib; panelLastOp[4:7] == 4'h0; endproperty
    a_lowNib: assert property (p_lowNib) else $error("low nibble set");
    property p_faultSet; |errorDetect |-> ##2
        (panelFault & $past(errorDetect, 2)) == $past(errorDetect, 2); endproperty
    a_faultSet: assert property (p_faultSet) else $error("fault bit lost");
    property p_load; lastOpLoad |-> ##2
        ((panelLastOp ^ $past(lastOpWrData, 2)) & 8'hF0) == 8'h00; endproperty
    a_load: assert property (p_load) else $error("load lost");
    property p_sense; $stable(senseFault)
        |-> senseData == (senseFault ? panelFault : panelLastOp); endproperty
    a_sense: assert property (p_sense) else $error("sense data");
    property p_halt; diagHalt [*4] |-> chanClock == 5'h00; endproperty
    a_halt: assert property (p_halt) else $error("clock while halted");
    property p_fast; chanClock[0] |=> !chanClock[0] [*3]; endproperty
    a_fast: assert property (p_fast) else $error("fast clock spacing");
endmodule
bind io_channel_cycle_steal_arbiter io_channel_cycle_steal_arbiter_properties chk (.*);
`default_nettype wire

// ### verification/tb_io_channel_cycle_steal_arbiter.sv
// Self-checking bench for the cycle-steal arbiter
`timescale 1ns/1ps
`default_nettype none
module tb_io_channel_cycle_steal_arbiter;
    logic ref_clk = 0, rst_n = 0, csRecognized = 0, intBlocked = 0, lastOpLoad = 0;
    logic faultLoad = 0, senseFault = 0, diagHalt = 0;
    logic [0:7] errorDetect = 0, lastOpWrData = 0, faultWrData = 0, reqMask = 0, idBusIn;
    logic [0:7] senseData, panelFault, panelLastOp, expFault, expLast;
    logic idCommand, grantValid;
    logic [2:0] grantBit;
    logic [4:0] chanClock;
    integer seed = 40, n_mismatch = 0, checks = 0, i, k, g, n, nCmd, nGnt;
    integer cnt [0:4];
    io_channel_cycle_steal_arbiter #(.MID_TICKS(13'h0004)) uut (.ref_clk(ref_clk),
        .rst_n(rst_n), .csRecognized(csRecognized), .intBlocked(intBlocked),
        .idBusIn(idBusIn), .idCommand(idCommand), .grantValid(grantValid),
        .grantBit(grantBit), .errorDetect(errorDetect), .lastOpLoad(lastOpLoad),
        .lastOpWrData(lastOpWrData), .faultLoad(faultLoad), .faultWrData(faultWrData),
        .senseFault(senseFault), .senseData(senseData), .panelFault(panelFault),
        .panelLastOp(panelLastOp), .diagHalt(diagHalt), .chanClock(chanClock));
    cs_attachments peer (.ref_clk(ref_clk), .idCommand(idCommand), .reqMask(reqMask),
        .idBus(idBusIn));
    always #12.5 ref_clk = ~ref_clk;
    task chk(input logic [0:7] got, input logic [0:7] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(negedge ref_clk);
    endtask
    task complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        cyc(20);
        rst_n = 1;
        expFault = 8'h00;
        expLast = 8'h00;
        cyc(2);
        chk(panelFault, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            errorDetect = (i % 3 == 1) ? $random(seed) : 8'h00;
            faultLoad = (i % 3 == 2);
            faultWrData = $random(seed) & 8'hFC;
            expFault = faultLoad ? faultWrData : expFault | errorDetect;
            lastOpLoad = (i % 4 == 3);
            lastOpWrData = $random(seed);
            if (lastOpLoad) expLast = {lastOpWrData[0:3], 4'h0};
            cyc(1);
            errorDetect = 8'h00;
            faultLoad = 0;
            lastOpLoad = 0;
            senseFault = 1;
            cyc(2);
            chk(senseData, expFault);
            chk(panelFault, expFault);
            reqMask = (i % 5 == 0) ? 8'h00 : $random(seed);
            intBlocked = (i % 7 == 6);
            csRecognized = 1;
            cyc(1);
            csRecognized = 0;
            nCmd = 0;
            nGnt = 0;
            repeat (8) begin
                nCmd = nCmd + idCommand;
                if (grantValid) nGnt = nGnt + 1;
                if (grantValid) g = grantBit;
                cyc(1);
            end
            n = 8;
            for (k = 7; k >= 0; k = k - 1) if (reqMask[k]) n = k;
            chk(nCmd[7:0], intBlocked ? 8'h00 : 8'h05);
            chk(nGnt[7:0], (intBlocked || n == 8) ? 8'h00 : 8'h01);
            if (!intBlocked && n < 8) begin
                chk(g[7:0], n[7:0]);
                if (expFault[6:7] == 2'b00) expLast = {1'b0, n[2:0], 4'h0};
            end
            intBlocked = 0;
            senseFault = 0;
            cyc(2);
            chk(senseData, expLast);
            chk(panelLastOp, expLast);
        end
        rst_n = 0;
        cyc(3);
        rst_n = 1;
        cyc(2);
        chk(panelLastOp, 8'h00);
        chk(panelFault, 8'h00);
        for (k = 0; k < 5; k++) cnt[k] = 0;
        repeat (160) begin
            for (k = 0; k < 5; k++) cnt[k] = cnt[k] + chanClock[k];
            cyc(1);
        end
        chk(cnt[0][7:0], 8'h28);
        chk(cnt[1][7:0], 8'h0A);
        chk(cnt[2][7:0], 8'h05);
        for (k = 0; k < 5; k++) cnt[k] = 0;
        repeat (32768) begin
            for (k = 0; k < 5; k++) cnt[k] = cnt[k] + chanClock[k];
            cyc(1);
        end
        chk(cnt[3][7:0], 8'h08);
        chk(cnt[4][7:0], 8'h01);
        diagHalt = 1;
        cyc(4);
        n = 0;
        repeat (40) begin
            n = n | chanClock;
            cyc(1);
        end
        chk(n[7:0], 8'h00);
        diagHalt = 0;
        cyc(4);
        n = 0;
        repeat (40) begin
            n = n + chanClock[0];
            cyc(1);
        end
        chk(n[7:0], 8'h0A);
        complete_run;
    end
endmodule
`default_nettype wire

// ### verilog/io_channel_cycle_steal_arbiter.v
// I/O channel: cycle-steal arbiter, fault byte, last-op register, channel clocks
//
// Behaviour
// [R1] Each detected error sets its own bit in the fault byte.
// [R2] Channel error recording ignores the processor's error-check disable.
// [R3] Processor can sense the fault byte during recovery.
// [R4] Last-operation register is sensed and loaded by the processor.
// [R5] Fault byte bits 6 and 7 decide the meaning of register bits 0-3.
// [R6] Register bits 4-7 are unused and always zero.
// [R7] Fault byte and last-operation register are shown on the panel.
// [R8] Grant needs system interrupt priority first, then attachment priority.
// [R9] After recognition the channel issues the sense cycle-steal ID command.
// [R10] Requesting attachments answer by driving their own bus bit.
// [R11] Highest set bus bit wins; bit 0 highest, bit 7 lowest.
// [R12] Bits 1,2,4,5,6,7 are assigned attachments; bits 0 and 3 unused.
// [R13] Upper hex digit of register records the granted bus bit number.
// [R14] Five channel clock pulses: 100ns, 512us, 1024us, 131ms, 1048ms.
// [R15] Channel clocks keep running through a processor check.
// [R16] Channel clocks can be halted during diagnostic testing.
// [R17] All channel clocks divide down one oscillator.
// [R18] No answer to the ID command: no grant, register unchanged.
// [R19] Reset clears fault byte and register and restarts the dividers.
`timescale 1ns/1ps
`default_nettype none
`include "io_channel_cycle_steal_arbiter_consts.vh"

module io_channel_cycle_steal_arbiter #(
    parameter [`MID_W-1:0] MID_TICKS =
        `MID_TICKS_DEFAULT
) (
    input wire ref_clk,
    input wire rst_n,
    input wire csRecognized,
    input wire intBlocked,
    input wire [0:7] idBusIn,
    output reg idCommand,
    output reg grantValid,
    output reg [2:0] grantBit,
    input wire [0:7] errorDetect,
    input wire lastOpLoad,
    input wire [0:7] lastOpWrData,
    input wire faultLoad,
    input wire [0:7] faultWrData,
    input wire senseFault,
    output reg [0:7] senseData,
    output reg [0:7] panelFault,
    output reg [0:7] panelLastOp,
    input wire diagHalt,
    output reg [4:0] chanClock
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_CMD = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    // Terminal counts other than MID_LAST worked out wide, then cut to counter width
    localparam integer FAST_CYC_I = `PULSE_FAST_NS / `CLK_PERIOD_NS;
    localparam integer FAST_LAST_I = FAST_CYC_I - 1;
    localparam integer R1024_LAST_I = `RATIO_1024 - 1;
    localparam integer R131_LAST_I = `RATIO_131 - 1;
    localparam integer R1048_LAST_I = `RATIO_1048 - 1;

    localparam [`FAST_W-1:0] FAST_LAST = FAST_LAST_I[`FAST_W-1:0];
    localparam [`MID_W-1:0] MID_LAST = MID_TICKS - 13'h0001;
    localparam [`R1024_W-1:0] R1024_LAST = R1024_LAST_I[`R1024_W-1:0];
    localparam [`R131_W-1:0] R131_LAST = R131_LAST_I[`R131_W-1:0];
    localparam [`R1048_W-1:0] R1048_LAST = R1048_LAST_I[`R1048_W-1:0];

    // Bus and halt pin synchronisers
    // Answers reach busSync two edges late, hence the late sample point
    reg [0:7] busMeta;
    reg [0:7] busSync;
    reg haltMeta;
    reg haltSync;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            busMeta <= 8'h00;
            busSync <= 8'h00;
            haltMeta <= 1'b0;
            haltSync <= 1'b0;
        end else begin
            busMeta <= idBusIn;
            busSync <= busMeta;
            haltMeta <= diagHalt;
            haltSync <= haltMeta;
        end
    end

    // Priority search over the answer bits
    // [R12] Unassigned bits 0 and 3 still ranked
    function [3:0] pickWinner;
        input [0:7] bits;
        integer k;
        begin
            pickWinner = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (bits[k]) begin
                    pickWinner = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    reg [1:0] state;
    reg [1:0] next_state;
    reg [3:0] cmdCount;
    reg [3:0] next_cmdCount;
    reg next_idCommand;
    reg next_grantValid;
    reg [2:0] next_grantBit;
    reg doGrant;
    wire [3:0] winner;

    // [R11] Fixed bit priority
    assign winner = pickWinner(busSync);

    always @* begin
        next_state = state;
        next_cmdCount = cmdCount;
        next_idCommand = idCommand;
        next_grantValid = 1'b0;
        next_grantBit = grantBit;
        doGrant = 1'b0;
        case (state)
            ST_IDLE: begin
                // [R8] Interrupt priority first
                if (csRecognized && !intBlocked) begin
                    next_state = ST_CMD;
                    next_cmdCount = 4'h0;
                    // [R9] Issue sense ID command
                    next_idCommand = 1'b1;
                end
            end
            ST_CMD: begin
                next_cmdCount = cmdCount + 4'h1;
                if (cmdCount == `ID_SAMPLE_AT) begin
                    next_state = ST_WAIT;
                    // [R10] Answers sampled from the bus
                    if (winner[3]) begin
                        // [R8] Attachment priority second
                        doGrant = 1'b1;
                        next_grantValid = 1'b1;
                        next_grantBit = winner[2:0];
                    end
                    // [R18] No answer means no grant
                end
            end
            ST_WAIT: begin
                // Command stands one cycle past the grant
                next_cmdCount = cmdCount + 4'h1;
                if (cmdCount == `ID_CMD_CYCLES) begin
                    next_idCommand = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_idCommand = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cmdCount <= 4'h0;
            idCommand <= 1'b0;
            grantValid <= 1'b0;
            grantBit <= 3'h0;
        end else begin
            state <= next_state;
            cmdCount <= next_cmdCount;
            idCommand <= next_idCommand;
            grantValid <= next_grantValid;
            grantBit <= next_grantBit;
        end
    end

    // Fault byte and last-operation register
    reg [0:7] faultByte;
    reg [0:7] lastOp;
    reg [0:7] next_faultByte;
    reg [0:7] next_lastOp;
    wire faultContext;

    // [R5] Fault context bits hold the digit against grants
    assign faultContext = faultByte[`FAULT_CTX_A] | faultByte[`FAULT_CTX_B];

    always @* begin
        // Processor load is how bits get cleared
        next_faultByte = faultByte;
        if (faultLoad) begin
            next_faultByte = faultWrData;
        end
        // [R1] Set per error kind; set wins over load
        // [R2] Not gated by any processor check disable
        next_faultByte = next_faultByte | errorDetect;
    end

    always @* begin
        next_lastOp = lastOp;
        // [R4] Processor load
        // Load beats a grant in the same cycle
        if (lastOpLoad) begin
            next_lastOp = lastOpWrData;
        end else if (doGrant && !faultContext) begin
            // [R13] Record granted bit number
            next_lastOp[0:3] = {1'b0, winner[2:0]};
        end
        // [R6] Low nibble carries nothing
        next_lastOp[4:7] = `LOW_NIBBLE;
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            // [R19] Clear on reset
            faultByte <= `FAULT_RESET;
            lastOp <= `LASTOP_RESET;
        end else begin
            faultByte <= next_faultByte;
            lastOp <= next_lastOp;
        end
    end

    // Sense and panel outputs
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            senseData <= 8'h00;
            panelFault <= 8'h00;
            panelLastOp <= 8'h00;
        end else begin
            // [R3] Sense either register
            if (senseFault) begin
                senseData <= faultByte;
            end else begin
                senseData <= lastOp;
            end
            // [R7] Panel display
            panelFault <= faultByte;
            panelLastOp <= lastOp;
        end
    end

    // Channel clock dividers
    reg [`FAST_W-1:0] fastCount;
    reg [`MID_W-1:0] midCount;
    reg [`R1024_W-1:0] c1024;
    reg [`R131_W-1:0] c131;
    reg [`R1048_W-1:0] c1048;
    wire fastWrap;
    wire midWrap;

    // [R17] Single oscillator chain
    assign fastWrap = (fastCount == FAST_LAST);
    assign midWrap = fastWrap && (midCount == MID_LAST);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            // [R19] Dividers restart
            fastCount <= {`FAST_W{1'b0}};
            midCount <= {`MID_W{1'b0}};
            c1024 <= {`R1024_W{1'b0}};
            c131 <= {`R131_W{1'b0}};
            c1048 <= {`R1048_W{1'b0}};
            chanClock <= 5'h00;
        end else if (haltSync) begin
            // [R16] Diagnostic halt freezes all clocks
            chanClock <= 5'h00;
        end else begin
            // [R15] Nothing else stops the clocks
            // [R14] Five periodic pulses
            if (fastWrap) begin
                fastCount <= {`FAST_W{1'b0}};
            end else begin
                fastCount <= fastCount + 3'h1;
            end
            // Slow pulses coincide with a 512 us pulse
            chanClock[0] <= fastWrap;
            chanClock[1] <= midWrap;
            chanClock[2] <= midWrap && (c1024 == R1024_LAST);
            chanClock[3] <= midWrap && (c131 == R131_LAST);
            chanClock[4] <= midWrap && (c1048 == R1048_LAST);
            if (fastWrap) begin
                if (midCount == MID_LAST) begin
                    midCount <= {`MID_W{1'b0}};
                end else begin
                    midCount <= midCount + 13'h0001;
                end
            end
            if (midWrap) begin
                c1024 <= c1024 + 1'b1;
                c131 <= c131 + 8'h01;
                c1048 <= c1048 + 11'h001;
            end
        end
    end

endmodule

`default_nettype wire
